// >>> verification/sdfm_tb.sv
// Purpose: Self-checking bench for the supply fault monitor
// Assumes: One pclk domain, APB slave answers with pready
// Notes:   Detectors pulsed one cycle, flags read back over APB
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_map.svh"

module testbench
	import sdfm_pkg::*;
;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, err, digital_supply_en, digital_reset_req;
	logic [1:0]  power_mode = 2'h1;
	logic [15:0] ot_evt = 16'h0000, ut_evt = 16'h0000;
	sdfm_det_s   det = '0;
	int          mismatches = 0, checked = 0, cycles = 0, n = 0, bad = 0;
	// Detector bit feeding each flag, status A then status B
	localparam int AMAP [8] = '{14, 12, 11, 9, 8, 2, 1, 0};
	localparam int BMAP [5] = '{7, 6, 5, 4, 3};

	sdfm_top sdfm_top_i (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.power_mode        (power_mode),
		.det               (det),
		.over_temp_evt     (ot_evt),
		.under_temp_evt    (ut_evt),
		.digital_supply_en (digital_supply_en),
		.digital_reset_req (digital_reset_req)
	);

	// Clock and hang guard; a few hundred cycles cover every test
	always #25 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	// Request held until pready is sampled high; no fixed latency assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Besides pready, only the bench-wide cycle ceiling ends this wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, q);
	endtask

	task automatic pulse(input logic [14:0] v);
		@(posedge pclk);
		det <= sdfm_det_s'(v);
		@(posedge pclk);
		det <= '0;
	endtask

	// Counts reset-request cycles and supply-enable lows within them
	task automatic watch_rst();
		n = 0;
		bad = 0;
		while (digital_reset_req !== 1'b1 && n < 5)
		begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (digital_reset_req === 1'b1 && n < 40)
		begin
			bad += (digital_supply_en !== 1'b1);
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd("status_a", `SDFM_OFF_FLT_A, 32'h0000_0000);
		rd("status_b", `SDFM_OFF_FLT_B, 32'h0000_0000);
		rd("ctrl", `SDFM_OFF_CTRL, 32'h0000_0001);
		rd("cause", `SDFM_OFF_CAUSE, 32'h0000_0002);
		rd("unmapped", 8'h18, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, err});
		$display("Test reset done");
	endtask

	// Alias off so each detector maps to exactly one flag
	task automatic t_flags();
		apb(1'b1, `SDFM_OFF_CTRL, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			pulse(15'h0001 << AMAP[i]);
			rd("status_a", `SDFM_OFF_FLT_A, 32'h0000_0001 << i);
			apb(1'b1, `SDFM_OFF_FLT_A, 32'h0000_0001 << i);
			rd("a_clear", `SDFM_OFF_FLT_A, 32'h0000_0000);
		end
		for (int i = 0; i < 5; i++)
		begin
			pulse(15'h0001 << BMAP[i]);
			rd("status_b", `SDFM_OFF_FLT_B, 32'h0000_0001 << i);
			rd("over_temp", `SDFM_OFF_OT, (i < 3) ? 32'h0000_FFFF : 32'h0000_0000);
			rd("under_temp", `SDFM_OFF_UT, (i < 3) ? 32'h0000_FFFF : 32'h0000_0000);
			apb(1'b1, `SDFM_OFF_FLT_B, 32'h0000_001F);
			apb(1'b1, `SDFM_OFF_OT, 32'h0000_FFFF);
			apb(1'b1, `SDFM_OFF_UT, 32'h0000_FFFF);
		end
		$display("Test flags done");
	endtask

	task automatic t_alias();
		apb(1'b1, `SDFM_OFF_CTRL, 32'h0000_0001);
		pulse(15'h4000);
		rd("alias_a", `SDFM_OFF_FLT_A, 32'h0000_0003);
		pulse(15'h0040);
		rd("alias_b", `SDFM_OFF_FLT_B, 32'h0000_0006);
		apb(1'b1, `SDFM_OFF_FLT_A, 32'h0000_00FF);
		apb(1'b1, `SDFM_OFF_FLT_B, 32'h0000_001F);
		apb(1'b1, `SDFM_OFF_OT, 32'h0000_FFFF);
		apb(1'b1, `SDFM_OFF_UT, 32'h0000_FFFF);
		$display("Test alias done");
	endtask

	// Monitor off must ignore every detector, sleep must not
	task automatic t_modes();
		for (int m = 0; m < 4; m += 3)
		begin
			power_mode <= 2'(m);
			pulse(15'h7FFF);
			rd("off_a", `SDFM_OFF_FLT_A, 32'h0000_0000);
			rd("off_b", `SDFM_OFF_FLT_B, 32'h0000_0000);
			rd("off_ot", `SDFM_OFF_OT, 32'h0000_0000);
			chk("off_rst", 32'h0000_0000, {31'h0, digital_reset_req});
		end
		power_mode <= `SDFM_MODE_SLEEP;
		pulse(15'h0200);
		rd("sleep_a", `SDFM_OFF_FLT_A, 32'h0000_0008);
		apb(1'b1, `SDFM_OFF_FLT_A, 32'h0000_0008);
		power_mode <= `SDFM_MODE_ACTIVE;
		$display("Test modes done");
	endtask

	task automatic t_analog_uv();
		pulse(15'h2000);
		watch_rst();
		chk("rst_len", 32'(`SDFM_RST_NS / `SDFM_CLK_NS), 32'(n));
		chk("en_low", 32'(`SDFM_RST_NS / `SDFM_CLK_NS), 32'(bad));
		chk("en_back", 32'h0000_0001, {31'h0, digital_supply_en});
		rd("cause", `SDFM_OFF_CAUSE, 32'h0000_0003);
		apb(1'b1, `SDFM_OFF_CAUSE, 32'h0000_0001);
		rd("cause_clr", `SDFM_OFF_CAUSE, 32'h0000_0002);
		// Alias is on, so the dip also marks analog oscillation
		rd("alias_uv", `SDFM_OFF_FLT_A, 32'h0000_0002);
		apb(1'b1, `SDFM_OFF_FLT_A, 32'h0000_00FF);
		$display("Test analog undervoltage done");
	endtask

	task automatic t_digital_uv();
		pulse(15'h0400);
		watch_rst();
		chk("rst_len", 32'(`SDFM_RST_NS / `SDFM_CLK_NS), 32'(n));
		chk("en_kept", 32'h0000_0000, 32'(bad));
		rd("cause", `SDFM_OFF_CAUSE, 32'h0000_0002);
		rd("no_flag_a", `SDFM_OFF_FLT_A, 32'h0000_0000);
		rd("no_flag_b", `SDFM_OFF_FLT_B, 32'h0000_0000);
		$display("Test digital undervoltage done");
	endtask

	// Mid-run reset drops sticky state and restores control defaults
	task automatic t_reset_mid();
		@(posedge pclk);
		ot_evt <= 16'h00A5;
		ut_evt <= 16'h5A00;
		pulse(15'h4000);
		ot_evt <= 16'h0000;
		ut_evt <= 16'h0000;
		rd("evt_ot", `SDFM_OFF_OT, 32'h0000_00A5);
		rd("evt_ut", `SDFM_OFF_UT, 32'h0000_5A00);
		rd("pre_rst_a", `SDFM_OFF_FLT_A, 32'h0000_0003);
		apb(1'b1, `SDFM_OFF_CTRL, 32'h0000_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd("rst_a", `SDFM_OFF_FLT_A, 32'h0000_0000);
		rd("rst_ot", `SDFM_OFF_OT, 32'h0000_0000);
		rd("rst_ctrl", `SDFM_OFF_CTRL, 32'h0000_0001);
		$display("Test mid-run reset done");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_flags();
		t_alias();
		t_modes();
		t_analog_uv();
		t_digital_uv();
		t_reset_mid();
		stop_test();
	end
endmodule

`default_nettype wire

// >>> verilog/sdfm_map.svh
// Purpose: Offsets, bit positions and timing for the supply monitor
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SDFM_MAP_SVH
`define SDFM_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SDFM_OFF_FLT_A   8'h00
`define SDFM_OFF_FLT_B   8'h04
`define SDFM_OFF_OT      8'h08
`define SDFM_OFF_UT      8'h0C
`define SDFM_OFF_CTRL    8'h10
`define SDFM_OFF_CAUSE   8'h14

// ****************************************
// Field positions
// ****************************************
`define SDFM_A_AOV       0
`define SDFM_A_AOSC      1
`define SDFM_A_DOV       2
`define SDFM_A_COV       3
`define SDFM_A_CUV       4
`define SDFM_A_HROPEN    5
`define SDFM_A_DGOPEN    6
`define SDFM_A_CGOPEN    7
`define SDFM_B_TOV       0
`define SDFM_B_TUV       1
`define SDFM_B_TOSC      2
`define SDFM_B_NUV       3
`define SDFM_B_HROSC     4
`define SDFM_CTRL_ALIAS  0
`define SDFM_CAUSE_AUV   0
`define SDFM_CAUSE_DSEN  1

// ****************************************
// Widths, reset values, modes, timing
// ****************************************
`define SDFM_A_W         8
`define SDFM_B_W         5
`define SDFM_TEMP_W      16
`define SDFM_CTRL_RST    1'h1
`define SDFM_MODE_ACTIVE 2'h1
`define SDFM_MODE_SLEEP  2'h2
`define SDFM_RST_NS      1000
`define SDFM_CLK_NS      50

`endif

// >>> verilog/sdfm_pkg.sv
// Purpose: Types shared by the supply monitor
// Assumes: Detector inputs are synchronous levels
// Notes:   One bit per comparator or open detector
package sdfm_pkg;

	// Raw detector levels, high while the condition holds
	typedef struct packed {
		logic an_ov;
		logic an_uv;
		logic an_osc;
		logic dg_ov;
		logic dg_uv;
		logic cm_ov;
		logic cm_uv;
		logic tr_ov;
		logic tr_uv;
		logic tr_osc;
		logic ng_uv;
		logic hr_osc;
		logic hr_open;
		logic dg_open;
		logic cm_open;
	} sdfm_det_s;

	typedef enum logic [1:0] {
		S_RUN,
		S_RST,
		S_WAIT
	} sdfm_state_e;

endpackage

// >>> verilog/sdfm_top.sv
// Purpose: Background supply and ground fault monitor with APB access
// Assumes: Detector and mode inputs synchronous to pclk
// Notes:   Fault bits are write-one-to-clear, a new event beats a clear
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdfm_map.svh"

// Contract
// [R1] Checks run only in active or sleep mode, continuously.
// [R2] Analog overvoltage sets analog over flag in status A.
// [R3] Analog undervoltage cuts digital supply, resets, then records reset cause.
// [R4] Analog oscillation sets analog osc flag in status A.
// [R5] Digital overvoltage sets digital over flag in status A.
// [R6] Digital undervoltage resets without any dedicated flag.
// [R7] Comm over or undervoltage sets matching comm flag in status A.
// [R8] Thermistor reference faults set status B flag and all temperature bits.
// [R9] Negative rail undervoltage sets its flag in status B only.
// [R10] High reference positive oscillation sets high reference osc flag.
// [R11] Return, digital ground, comm ground open set matching flag in A.
// [R12] Over or undervoltage may also raise matching oscillation flag.
// [R13] Flags stay set until host clears them or reset.
module sdfm_top
	import sdfm_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [1:0]        power_mode,
	input  wire sdfm_det_s         det,
	input  wire logic [15:0]       over_temp_evt,
	input  wire logic [15:0]       under_temp_evt,
	output logic                   digital_supply_en,
	output logic                   digital_reset_req
);

	// ****************************************
	// Constants and state
	// ****************************************
	localparam int unsigned RST_CYC_I =
		(`SDFM_RST_NS + `SDFM_CLK_NS - 1) / `SDFM_CLK_NS;
	localparam logic [4:0] RST_CYC = 5'(RST_CYC_I);

	logic [`SDFM_A_W-1:0]    flt_a_ff, nxt_flt_a, set_a, clr_a, keep_a;
	logic [`SDFM_B_W-1:0]    flt_b_ff, nxt_flt_b, set_b, clr_b;
	logic [`SDFM_TEMP_W-1:0] ot_ff, nxt_ot, ut_ff, nxt_ut, clr_ot, clr_ut;
	logic                    ctrl_ff, nxt_ctrl;
	logic                    cause_ff, nxt_cause, clr_cause;
	logic                    pend_ff, nxt_pend;
	logic                    sup_en_ff, nxt_sup_en;
	logic                    rst_req_ff, nxt_rst_req;
	logic [4:0]              cnt_ff, nxt_cnt;
	sdfm_state_e             st_ff, nxt_st;
	logic [31:0]             prdata_ff, nxt_prdata;
	logic                    pready_ff, nxt_pready;
	logic                    pslverr_ff, nxt_pslverr;
	logic                    mon_on, wr, tr_any, alias_en, hit;

	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign digital_supply_en = sup_en_ff;
	assign digital_reset_req = rst_req_ff;

	// ****************************************
	// Detection
	// ****************************************
	// Checkers gated by power mode
	always_comb
	begin
		mon_on = (power_mode == `SDFM_MODE_ACTIVE) ||
			(power_mode == `SDFM_MODE_SLEEP); // [R1]
		alias_en = ctrl_ff;
		tr_any = mon_on && (det.tr_ov || det.tr_uv || det.tr_osc);
		set_a = '0;
		set_b = '0;
		set_a[`SDFM_A_AOV]    = mon_on && det.an_ov; // [R2]
		set_a[`SDFM_A_AOSC]   = mon_on && (det.an_osc || // [R4]
			(alias_en && (det.an_ov || det.an_uv))); // [R12]
		set_a[`SDFM_A_DOV]    = mon_on && det.dg_ov; // [R5]
		set_a[`SDFM_A_COV]    = mon_on && det.cm_ov; // [R7]
		set_a[`SDFM_A_CUV]    = mon_on && det.cm_uv; // [R7]
		set_a[`SDFM_A_HROPEN] = mon_on && det.hr_open; // [R11]
		set_a[`SDFM_A_DGOPEN] = mon_on && det.dg_open; // [R11]
		set_a[`SDFM_A_CGOPEN] = mon_on && det.cm_open; // [R11]
		set_b[`SDFM_B_TOV]    = mon_on && det.tr_ov; // [R8]
		set_b[`SDFM_B_TUV]    = mon_on && det.tr_uv; // [R8]
		set_b[`SDFM_B_TOSC]   = mon_on && (det.tr_osc ||
			(alias_en && (det.tr_ov || det.tr_uv))); // [R12]
		set_b[`SDFM_B_NUV]    = mon_on && det.ng_uv; // [R9]
		set_b[`SDFM_B_HROSC]  = mon_on && det.hr_osc; // [R10]
	end

	// ****************************************
	// Sticky flags
	// ****************************************
	// Write-one-to-clear; set wins so no event is lost
	always_comb
	begin
		wr = psel && penable && pwrite && pready_ff;
		clr_a = (wr && paddr == `SDFM_OFF_FLT_A) ? pwdata[`SDFM_A_W-1:0] : '0;
		clr_b = (wr && paddr == `SDFM_OFF_FLT_B) ? pwdata[`SDFM_B_W-1:0] : '0;
		clr_ot = (wr && paddr == `SDFM_OFF_OT) ? pwdata[`SDFM_TEMP_W-1:0] : '0;
		clr_ut = (wr && paddr == `SDFM_OFF_UT) ? pwdata[`SDFM_TEMP_W-1:0] : '0;
		clr_cause = wr && paddr == `SDFM_OFF_CAUSE && pwdata[`SDFM_CAUSE_AUV];
		keep_a = flt_a_ff & ~clr_a;
		nxt_flt_a = keep_a | set_a; // [R13]
		nxt_flt_b = (flt_b_ff & ~clr_b) | set_b; // [R13]
		nxt_ot = (ot_ff & ~clr_ot) | (mon_on ? over_temp_evt : '0);
		nxt_ut = (ut_ff & ~clr_ut) | (mon_on ? under_temp_evt : '0);
		if (tr_any)
		begin
			nxt_ot = '1; // [R8]
			nxt_ut = '1; // [R8]
		end
		nxt_ctrl = ctrl_ff;
		if (wr && paddr == `SDFM_OFF_CTRL)
		begin
			nxt_ctrl = pwdata[`SDFM_CTRL_ALIAS];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flt_a_ff <= '0;
			flt_b_ff <= '0;
			ot_ff    <= '0;
			ut_ff    <= '0;
			ctrl_ff  <= `SDFM_CTRL_RST;
		end
		else
		begin
			flt_a_ff <= nxt_flt_a;
			flt_b_ff <= nxt_flt_b;
			ot_ff    <= nxt_ot;
			ut_ff    <= nxt_ut;
			ctrl_ff  <= nxt_ctrl;
		end
	end

	// ****************************************
	// Supply cut and digital reset
	// ****************************************
	// Analog dip holds digital supply off through the reset pulse and until it recovers
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_pend = pend_ff;
		nxt_sup_en = sup_en_ff;
		nxt_cause = cause_ff && !clr_cause;
		case (st_ff)
			S_RUN:
			begin
				nxt_cnt = '0;
				if (mon_on && det.an_uv)
				begin
					nxt_sup_en = 1'b0; // [R3]
					nxt_pend = 1'b1;
					nxt_st = S_RST;
				end
				else if (mon_on && det.dg_uv)
				begin
					nxt_pend = 1'b0; // [R6]
					nxt_st = S_RST;
				end
			end
			S_RST:
			begin
				nxt_cnt = cnt_ff + 5'h01;
				if (cnt_ff == RST_CYC - 5'h01)
				begin
					nxt_st = S_WAIT;
				end
			end
			S_WAIT:
			begin
				// Cause is recorded only after the reset pulse ends
				if (!(mon_on && det.an_uv))
				begin
					nxt_sup_en = 1'b1;
					// Keep a same-cycle clear unless this reset sets the cause again
					nxt_cause = (cause_ff && !clr_cause) || pend_ff; // [R3]
					nxt_pend = 1'b0;
					nxt_st = S_RUN;
				end
			end
			default:
			begin
				nxt_st = S_RUN;
			end
		endcase
		nxt_rst_req = (nxt_st == S_RST);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff      <= S_RUN;
			cnt_ff     <= '0;
			pend_ff    <= 1'b0;
			sup_en_ff  <= 1'b1;
			rst_req_ff <= 1'b0;
			cause_ff   <= 1'b0;
		end
		else
		begin
			st_ff      <= nxt_st;
			cnt_ff     <= nxt_cnt;
			pend_ff    <= nxt_pend;
			sup_en_ff  <= nxt_sup_en;
			rst_req_ff <= nxt_rst_req;
			cause_ff   <= nxt_cause;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// One wait-free access phase; data captured in setup
	always_comb
	begin
		hit = 1'b1;
		nxt_prdata = prdata_ff;
		case (paddr)
			`SDFM_OFF_FLT_A: nxt_prdata = {24'h0000_00, flt_a_ff};
			`SDFM_OFF_FLT_B: nxt_prdata = {27'h000_0000, flt_b_ff};
			`SDFM_OFF_OT:    nxt_prdata = {16'h0000, ot_ff};
			`SDFM_OFF_UT:    nxt_prdata = {16'h0000, ut_ff};
			`SDFM_OFF_CTRL:  nxt_prdata = {31'h0000_0000, ctrl_ff};
			`SDFM_OFF_CAUSE: nxt_prdata = {30'h0000_0000, sup_en_ff, cause_ff};
			default:
			begin
				hit = 1'b0;
				nxt_prdata = '0;
			end
		endcase
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && !hit;
		if (!(psel && !penable))
		begin
			nxt_prdata = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_auv_start;
		st_ff == S_RUN && mon_on && det.an_uv;
	endsequence

	sequence s_rst_hold;
		(!sup_en_ff && rst_req_ff) [*8];
	endsequence

	a_idle_hold: assert property (!mon_on && clr_a == '0 |=> // [R1]
		flt_a_ff == $past(flt_a_ff))
		else $error("status A changed while monitor idle");
	a_aov_set: assert property (mon_on && det.an_ov |=> // [R2]
		flt_a_ff[`SDFM_A_AOV])
		else $error("analog over flag not set");
	a_auv_reset: assert property (s_auv_start |=> s_rst_hold) // [R3]
		else $error("analog under did not cut supply and reset");
	a_auv_cause: assert property (st_ff == S_WAIT && pend_ff && // [R3]
		!(mon_on && det.an_uv) |=> cause_ff && sup_en_ff)
		else $error("reset cause not recorded");
	a_aosc_set: assert property (mon_on && det.an_osc |=> // [R4]
		flt_a_ff[`SDFM_A_AOSC])
		else $error("analog osc flag not set");
	a_dov_set: assert property (mon_on && det.dg_ov |=> // [R5]
		flt_a_ff[`SDFM_A_DOV])
		else $error("digital over flag not set");
	a_duv_reset: assert property (st_ff == S_RUN && mon_on && // [R6]
		det.dg_uv && !det.an_uv |=> rst_req_ff && sup_en_ff && !pend_ff)
		else $error("digital under reset wrong");
	a_comm_set: assert property (mon_on && det.cm_uv |=> // [R7]
		flt_a_ff[`SDFM_A_CUV])
		else $error("comm under flag not set");
	a_comm_over: assert property (mon_on && det.cm_ov |=> // [R7]
		flt_a_ff[`SDFM_A_COV])
		else $error("comm over flag not set");
	a_temp_force: assert property (tr_any |=> &ot_ff && &ut_ff) // [R8]
		else $error("temperature registers not forced");
	a_neg_set: assert property (mon_on && det.ng_uv |=> // [R9]
		flt_b_ff[`SDFM_B_NUV])
		else $error("negative rail flag not set");
	a_hrosc_set: assert property (mon_on && det.hr_osc |=> // [R10]
		flt_b_ff[`SDFM_B_HROSC])
		else $error("high ref osc flag not set");
	a_open_set: assert property (mon_on && det.dg_open |=> // [R11]
		flt_a_ff[`SDFM_A_DGOPEN])
		else $error("ground open flag not set");
	a_alias_osc: assert property (mon_on && alias_en && det.tr_uv |=> // [R12]
		flt_b_ff[`SDFM_B_TOSC])
		else $error("thermistor osc alias missing");
	a_flag_sticky: assert property (1'b1 |=> // [R13]
		(flt_a_ff & $past(keep_a)) == $past(keep_a))
		else $error("status A flag dropped without clear");

endmodule
`default_nettype wire
